// *** hw/cis_top.sv ***
// CAN interrupt flag and enable registers with one interrupt request line.
// Assumes error-state levels and event pulses come from the protocol
// engine on clk_i, and a classic Wishbone master on the same clock.
//
// Summary of operation
// R1 - Transmit bus-off status follows transmitter state
// R2 - Transmit error-passive status follows transmitter, read-only
// R3 - Receive error-passive status follows receiver, read-only
// R4 - Transmit warning status follows transmitter warning state
// R5 - Receive warning status follows receiver warning state
// R6 - Combined warning is OR of both warnings
// R7 - Flags readable; writing zero clears, one keeps
// R8 - Error flag set on any status-bit change
// R9 - Invalid message sets sticky invalid-message flag
// R10 - Bus wake-up activity sets sticky wake-up flag
// R11 - FIFO almost full sets sticky flag
// R12 - Lost incoming message sets receive overflow flag
// R13 - Stored received message sets receive buffer flag
// R14 - Transmit buffer event sets transmit buffer flag
// R15 - Per-flag enable bits, read/write, reset zero
// R16 - Unimplemented register bits always read zero
// R17 - Interrupt high while any enabled flag set
// R18 - Hardware set wins over same-cycle software clear
`timescale 1ns/1ns
`default_nettype none

module cis_top
	import cis_pkg::*;
#(
	parameter int AW = CIS_AW_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [AW-1:0] wb_adr_i,
	input wire logic [CIS_SELW-1:0] wb_sel_i,
	input wire logic [CIS_DW-1:0] wb_dat_i,
	output logic [CIS_DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic tx_bus_off_state_i,
	input wire logic tx_error_passive_state_i,
	input wire logic rx_error_passive_state_i,
	input wire logic tx_error_warning_state_i,
	input wire logic rx_error_warning_state_i,
	input wire logic invalid_message_i,
	input wire logic bus_wakeup_i,
	input wire logic fifo_almost_full_i,
	input wire logic rx_overflow_i,
	input wire logic rx_buffer_i,
	input wire logic tx_buffer_i,
	output logic irq_o
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (AW < 3 || AW > 32) begin : g_bad_aw
		$error("cis_top: AW must lie between 3 and 32");
	end

	if (CIS_STAT_LSB + CIS_STAT_W > 14 || CIS_EVT_W != 8) begin : g_bad_map
		$error("cis_top: status and event fields do not fit the flag register");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [CIS_STAT_W-1:0] stat;
		logic [CIS_EVT_W-1:0] en;
		logic irq;
	} cis_state_t;

	cis_state_t st_q, st_d;
	logic [CIS_STAT_W-1:0] stat_next;
	logic [CIS_EVT_W-1:0] evt_set;
	logic [CIS_EVT_W-1:0] evt_clr;
	logic [CIS_EVT_W-1:0] flags;
	logic [CIS_EVT_W-1:0] flags_next;
	logic [CIS_DW-1:0] rd_data;
	logic [15:0] flag_reg;
	logic wr;
	logic hit_flags;
	logic hit_en;
	logic lane0;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	cis_wb_slave u_wb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.cyc_i(wb_cyc_i),
		.stb_i(wb_stb_i),
		.we_i(wb_we_i),
		.rd_data_i(rd_data),
		.ack_o(wb_ack_o),
		.dat_o(wb_dat_o),
		.wr_o(wr)
	);

	// Byte address decode; unmapped words read zero and ignore writes
	always_comb begin
		hit_flags = (wb_adr_i == AW'(CIS_OFS_FLAGS));
		hit_en = (wb_adr_i == AW'(CIS_OFS_ENABLES));
		lane0 = wb_sel_i[0];
		flag_reg = {2'b00, st_q.stat, flags};
		rd_data = '0;
		if (hit_flags) begin
			rd_data = {16'h0000, flag_reg}; // [R7] [R16]
		end else if (hit_en) begin
			rd_data = {24'h000000, st_q.en & CIS_EVT_IMPL}; // [R16]
		end
	end

	// ------------------------------------------------------------
	// Error-state status
	// ------------------------------------------------------------
	// Status bits sit in the read-only upper byte, writes never reach them
	always_comb begin
		stat_next = CIS_STAT_RST;
		stat_next[CIS_BIT_TX_BUS_OFF - CIS_STAT_LSB] = tx_bus_off_state_i; // [R1]
		stat_next[CIS_BIT_TX_PASSIVE - CIS_STAT_LSB] = tx_error_passive_state_i; // [R2]
		stat_next[CIS_BIT_RX_PASSIVE - CIS_STAT_LSB] = rx_error_passive_state_i; // [R3]
		stat_next[CIS_BIT_TX_WARNING - CIS_STAT_LSB] = tx_error_warning_state_i; // [R4]
		stat_next[CIS_BIT_RX_WARNING - CIS_STAT_LSB] = rx_error_warning_state_i; // [R5]
		stat_next[CIS_BIT_ANY_WARNING - CIS_STAT_LSB] =
			tx_error_warning_state_i | rx_error_warning_state_i; // [R6]
	end

	// ------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------
	always_comb begin
		evt_set = '0;
		evt_set[CIS_BIT_INVALID_MSG] = invalid_message_i; // [R9]
		evt_set[CIS_BIT_WAKEUP] = bus_wakeup_i; // [R10]
		evt_set[CIS_BIT_ERROR] = (stat_next != st_q.stat); // [R8]
		evt_set[CIS_BIT_FIFO_FULL] = fifo_almost_full_i; // [R11]
		evt_set[CIS_BIT_RX_OVERFLOW] = rx_overflow_i; // [R12]
		evt_set[CIS_BIT_RX_BUFFER] = rx_buffer_i; // [R13]
		evt_set[CIS_BIT_TX_BUFFER] = tx_buffer_i; // [R14]
		evt_clr = '0;
		if (wr && hit_flags && lane0) begin
			evt_clr = ~wb_dat_i[CIS_EVT_W-1:0]; // [R7]
		end
		flags_next = ((flags & ~evt_clr) | evt_set) & CIS_EVT_IMPL; // [R18]
	end

	cis_flag_bank u_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.set_i(evt_set),
		.clr_i(evt_clr),
		.flags_o(flags)
	);

	// ------------------------------------------------------------
	// Enables and interrupt request
	// ------------------------------------------------------------
	// The request is registered from next values so it moves with the flags
	always_comb begin
		st_d = st_q;
		st_d.stat = stat_next;
		if (wr && hit_en && lane0) begin
			st_d.en = wb_dat_i[CIS_EVT_W-1:0] & CIS_EVT_IMPL; // [R15]
		end
		st_d.irq = |(flags_next & st_d.en); // [R17]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q.stat <= CIS_STAT_RST;
			st_q.en <= CIS_EN_RST;
			st_q.irq <= 1'b0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	assign irq_o = st_q.irq;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence seq_clear_write;
		ce_i && wr && hit_flags && lane0;
	endsequence

	sequence seq_enable_write;
		ce_i && wr && hit_en && lane0;
	endsequence

	AST_BUS_OFF_TRACKS: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		ce_i |=> st_q.stat[CIS_BIT_TX_BUS_OFF - CIS_STAT_LSB] == $past(tx_bus_off_state_i))
		else $error("bus-off status does not follow transmitter");

	AST_PASSIVE_TRACKS: assert property (@(posedge clk_i) disable iff (rst_i) // [R2] [R3]
		ce_i |=> (st_q.stat[CIS_BIT_TX_PASSIVE - CIS_STAT_LSB] == $past(tx_error_passive_state_i))
		&& (st_q.stat[CIS_BIT_RX_PASSIVE - CIS_STAT_LSB] == $past(rx_error_passive_state_i)))
		else $error("error-passive status does not follow engine");

	AST_WARNING_TRACKS: assert property (@(posedge clk_i) disable iff (rst_i) // [R4] [R5]
		ce_i |=> (st_q.stat[CIS_BIT_TX_WARNING - CIS_STAT_LSB] == $past(tx_error_warning_state_i))
		&& (st_q.stat[CIS_BIT_RX_WARNING - CIS_STAT_LSB] == $past(rx_error_warning_state_i)))
		else $error("warning status does not follow engine");

	AST_ANY_WARNING: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		flag_reg[CIS_BIT_ANY_WARNING] ==
		(flag_reg[CIS_BIT_TX_WARNING] | flag_reg[CIS_BIT_RX_WARNING]))
		else $error("combined warning is not the OR of both warnings");

	AST_ERROR_ON_CHANGE: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		ce_i |=> (st_q.stat == $past(st_q.stat)) || flags[CIS_BIT_ERROR])
		else $error("status change did not raise the error flag");

	AST_EVENT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // [R9] [R10] [R11]
		(ce_i && (invalid_message_i || bus_wakeup_i || fifo_almost_full_i))
		|=> (flags[CIS_BIT_INVALID_MSG] || !$past(invalid_message_i))
		&& (flags[CIS_BIT_WAKEUP] || !$past(bus_wakeup_i))
		&& (flags[CIS_BIT_FIFO_FULL] || !$past(fifo_almost_full_i)))
		else $error("event did not set its flag");

	AST_BUFFER_EVENTS: assert property (@(posedge clk_i) disable iff (rst_i) // [R12] [R13] [R14]
		ce_i |=> ((flags & 8'h07) & {5'h00, $past(rx_overflow_i), $past(rx_buffer_i),
		$past(tx_buffer_i)}) == {5'h00, $past(rx_overflow_i), $past(rx_buffer_i), $past(tx_buffer_i)})
		else $error("buffer event did not set its flag");

	AST_WRITE_ZERO_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(seq_clear_write and (ce_i && evt_set == 8'h00))
		|=> flags == ($past(flags) & $past(wb_dat_i[CIS_EVT_W-1:0])))
		else $error("flag write did not clear exactly the zero bits");

	AST_SET_BEATS_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		seq_clear_write |=> (flags & $past(evt_set)) == $past(evt_set))
		else $error("software clear swallowed a hardware event");

	AST_ENABLE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		seq_enable_write |=> st_q.en == ($past(wb_dat_i[CIS_EVT_W-1:0]) & CIS_EVT_IMPL))
		else $error("enable register did not take the written value");

	AST_ENABLE_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		$fell(rst_i) |-> st_q.en == CIS_EN_RST && flags == CIS_FLAGS_RST && !irq_o)
		else $error("enables or flags not zero after reset");

	AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		wb_ack_o |-> wb_dat_o[31:14] == 18'h00000 && !wb_dat_o[4]
		&& (!$past(hit_en) || wb_dat_o[15:8] == 8'h00))
		else $error("unimplemented bits read as one");

	AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
		irq_o == |(flags & st_q.en))
		else $error("interrupt line disagrees with flags and enables");

	AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) ##1 (ce_i && wb_ack_o) |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	// ------------------------------------------------------------
	// Bus data and freeze checks
	// ------------------------------------------------------------
	// Read data is captured on the same edge that raises ack, so these look one edge back
	sequence seq_read_answer;
		$rose(wb_ack_o) && !$past(wb_we_i);
	endsequence

	sequence seq_write_answer;
		$rose(wb_ack_o) && $past(wb_we_i);
	endsequence

	AST_READ_ENABLES: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		(seq_read_answer and $past(hit_en)) |-> wb_dat_o[CIS_EVT_W-1:0] == $past(st_q.en))
		else $error("enable read returned the wrong value");

	AST_READ_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(seq_read_answer and $past(hit_flags)) |-> wb_dat_o[15:0] == $past({2'b00, st_q.stat, flags}))
		else $error("flag read returned the wrong value");

	AST_READ_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		(seq_read_answer and $past(!hit_flags && !hit_en)) |-> wb_dat_o == CIS_DAT_RST)
		else $error("unmapped read returned nonzero data");

	AST_WRITE_DATA_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		seq_write_answer |-> wb_dat_o == CIS_DAT_RST)
		else $error("write answer carried read data");

	AST_ACK_NEEDS_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");

	AST_CE_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> st_q == $past(st_q) && flags == $past(flags)
		&& wb_ack_o == $past(wb_ack_o) && wb_dat_o == $past(wb_dat_o))
		else $error("state moved while the clock enable was low");

	AST_ENABLE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		!(ce_i && wr && hit_en && lane0) |=> st_q.en == $past(st_q.en))
		else $error("enables changed without an enable write");

	AST_SEL_GATES_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(ce_i && wr && hit_flags && !lane0 && evt_set == 8'h00) |=> flags == $past(flags))
		else $error("write without the low byte lane changed the flags");

	// ------------------------------------------------------------
	// Status, error and interrupt checks
	// ------------------------------------------------------------
	sequence seq_error_rise;
		!flags[CIS_BIT_ERROR] ##1 flags[CIS_BIT_ERROR];
	endsequence

	AST_ERROR_HAS_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		seq_error_rise |-> st_q.stat != $past(st_q.stat))
		else $error("error flag rose with no status change");

	AST_ANY_WARNING_INPUT: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		ce_i |=> st_q.stat[CIS_BIT_ANY_WARNING - CIS_STAT_LSB]
		== $past(tx_error_warning_state_i || rx_error_warning_state_i))
		else $error("combined warning does not follow the engine");

	AST_IRQ_ON_EVENT: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
		(ce_i && rx_buffer_i && st_q.en[CIS_BIT_RX_BUFFER] && !(wr && hit_en && lane0)) |=> irq_o)
		else $error("enabled event did not raise the interrupt");

	AST_RESET_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> !wb_ack_o && wb_dat_o == CIS_DAT_RST && st_q.stat == CIS_STAT_RST)
		else $error("bus or status not idle after reset");

	// ------------------------------------------------------------
	// Per-flag checks
	// ------------------------------------------------------------
	// A flag may only fall on a zero written to its own bit
	for (genvar i = 0; i < CIS_EVT_W; i++) begin : g_flag_chk
		if (CIS_EVT_IMPL[i]) begin : g_impl
			AST_FLAG_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i) // [R9] [R10] [R11]
				flags[i] && !(ce_i && wr && hit_flags && lane0 && !wb_dat_i[i]) |=> flags[i])
				else $error("flag fell without a zero write");
		end else begin : g_absent
			AST_ABSENT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
				!flags[i] && !st_q.en[i])
				else $error("unimplemented flag or enable bit is set");
		end
	end

endmodule
`default_nettype wire

// *** hw/cis_pkg.sv ***
// Shared constants of the CAN interrupt flag and enable block.
// Assumes a 32-bit classic Wishbone register bus; only the low half word is used.
package cis_pkg;

	// ------------------------------------------------------------
	// Bus geometry and register map
	// ------------------------------------------------------------
	localparam int CIS_DW = 32;
	localparam int CIS_SELW = CIS_DW / 8;
	localparam int CIS_AW_DEF = 8;
	localparam logic [7:0] CIS_OFS_FLAGS = 8'h00;
	localparam logic [7:0] CIS_OFS_ENABLES = 8'h04;

	// ------------------------------------------------------------
	// Field positions of the flag register
	// ------------------------------------------------------------
	localparam int CIS_BIT_TX_BUS_OFF = 13;
	localparam int CIS_BIT_TX_PASSIVE = 12;
	localparam int CIS_BIT_RX_PASSIVE = 11;
	localparam int CIS_BIT_TX_WARNING = 10;
	localparam int CIS_BIT_RX_WARNING = 9;
	localparam int CIS_BIT_ANY_WARNING = 8;
	localparam int CIS_BIT_INVALID_MSG = 7;
	localparam int CIS_BIT_WAKEUP = 6;
	localparam int CIS_BIT_ERROR = 5;
	localparam int CIS_BIT_FIFO_FULL = 3;
	localparam int CIS_BIT_RX_OVERFLOW = 2;
	localparam int CIS_BIT_RX_BUFFER = 1;
	localparam int CIS_BIT_TX_BUFFER = 0;
	localparam int CIS_STAT_LSB = 8;
	localparam int CIS_STAT_W = 6;
	localparam int CIS_EVT_W = 8;

	// Implemented event positions; bit 4 is absent in both registers
	localparam logic [7:0] CIS_EVT_IMPL = 8'hef;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] CIS_FLAGS_RST = 8'h00;
	localparam logic [7:0] CIS_EN_RST = 8'h00;
	localparam logic [5:0] CIS_STAT_RST = 6'h00;
	localparam logic [31:0] CIS_DAT_RST = 32'h0000_0000;

endpackage

// *** hw/cis_flag_bank.sv ***
// Sticky event flags with hardware set and software clear.
// Assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module cis_flag_bank
	import cis_pkg::*;
#(
	parameter int W = CIS_EVT_W,
	parameter logic [W-1:0] IMPL = CIS_EVT_IMPL
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] flags_o
);

	typedef struct packed {
		logic [W-1:0] flags;
	} cis_bank_state_t;

	cis_bank_state_t st_q, st_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Set is ORed in after the clear so a coincident event survives
	always_comb begin
		st_d = st_q;
		st_d.flags = ((st_q.flags & ~clr_i) | set_i) & IMPL; // [R18] [R7]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q.flags <= '0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	assign flags_o = st_q.flags;

endmodule
`default_nettype wire

// *** hw/cis_wb_slave.sv ***
// Classic Wishbone slave front end: registered ack and read data.
// Assumes the master holds its request until it samples ack high.
`timescale 1ns/1ns
`default_nettype none

module cis_wb_slave
	import cis_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [CIS_DW-1:0] rd_data_i,
	output logic ack_o,
	output logic [CIS_DW-1:0] dat_o,
	output logic wr_o
);

	typedef struct packed {
		logic ack;
		logic [CIS_DW-1:0] dat;
	} cis_wb_state_t;

	cis_wb_state_t st_q, st_d;
	logic req;

	// ------------------------------------------------------------
	// Handshake
	// ------------------------------------------------------------
	// Ack one cycle after the request, dropped the cycle after it
	always_comb begin
		req = cyc_i & stb_i;
		st_d = st_q;
		st_d.ack = req & ~st_q.ack;
		if (req & ~st_q.ack) begin
			st_d.dat = we_i ? CIS_DAT_RST : rd_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q.ack <= 1'b0;
			st_q.dat <= CIS_DAT_RST;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	// Write lands on the edge where the master samples ack
	assign wr_o = req & we_i & st_q.ack & ce_i;
	assign ack_o = st_q.ack;
	assign dat_o = st_q.dat;

endmodule
`default_nettype wire

// *** testbench/cis_engine_model.sv ***
// Stand-in for the CAN protocol engine that feeds the interrupt block.
// Assumes the bench asks for error states and events on the same clock.
`timescale 1ns/1ns
`default_nettype none

module cis_engine_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] state_req_i,
	input wire logic [5:0] evt_req_i,
	output logic [4:0] state_o,
	output logic [5:0] evt_o
);
	// ------------------------------------------------------------
	// Error-state levels and event pulses
	// ------------------------------------------------------------
	// States are levels; events last one cycle, so each occurrence is reported once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_o <= 5'h00;
			evt_o <= 6'h00;
		end else begin
			state_o <= state_req_i;
			evt_o <= evt_req_i;
		end
	end
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the CAN interrupt flag and enable block.
// Assumes a single 100 MHz clock and a classic Wishbone master in the bench.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import cis_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] d;
	logic ack;
	logic irq;
	logic [4:0] st_req = 5'h00;
	logic [4:0] st;
	logic [5:0] ev_req = 6'h00;
	logic [5:0] ev;
	int num_errors = 0;
	int cmp_count = 0;
	int pos[6] = '{7, 6, 3, 2, 1, 0};

	always #5 clk = ~clk;

	cis_engine_model eng_u (.clk_i(clk), .rst_i(rst), .state_req_i(st_req), .evt_req_i(ev_req),
		.state_o(st), .evt_o(ev));

	cis_top dut_u (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.tx_bus_off_state_i(st[4]), .tx_error_passive_state_i(st[3]), .rx_error_passive_state_i(st[2]),
		.tx_error_warning_state_i(st[1]), .rx_error_warning_state_i(st[0]),
		.invalid_message_i(ev[5]), .bus_wakeup_i(ev[4]), .fifo_almost_full_i(ev[3]),
		.rx_overflow_i(ev[2]), .rx_buffer_i(ev[1]), .tx_buffer_i(ev[0]), .irq_o(irq));

	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Event request rides with the strobe so it lands on the write edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
		input logic [5:0] e);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= wd;
		sel <= s;
		ev_req <= e;
		do begin
			@(posedge clk);
			ev_req <= 6'h00;
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			num_errors++;
			$display("mismatch bus ack expected 1 seen %b", ack);
			test_done();
		end
		d = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [5:0] e = 6'h00);
		bus(1'b1, a, v, 4'hf, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0000_0000, 4'hf, 6'h00);
		chk(what, d, exp);
	endtask

	task automatic irq_chk(input logic exp);
		@(posedge clk);
		chk("irq", {31'h0, irq}, {31'h0, exp});
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd(CIS_OFS_FLAGS, 32'h0000_0000, "flags after reset");
		rd(CIS_OFS_ENABLES, 32'h0000_0000, "enables after reset");
		irq_chk(1'b0);
		$display("test reset done");
	endtask

	task automatic t_enables;
		wr(CIS_OFS_ENABLES, 32'hffff_ffff);
		rd(CIS_OFS_ENABLES, 32'h0000_00ef, "enables all ones");
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, 32'h0000_0000, "unmapped");
		wr(CIS_OFS_ENABLES, 32'h0000_0000);
		rd(CIS_OFS_ENABLES, 32'h0000_0000, "enables cleared");
		$display("test enables done");
	endtask

	task automatic t_events;
		logic [31:0] exp;
		bus(1'b0, CIS_OFS_FLAGS, 32'h0000_0000, 4'hf, 6'h3f);
		rd(CIS_OFS_FLAGS, 32'h0000_00cf, "events set");
		// Low byte lane not selected, so the zeros must be ignored
		bus(1'b1, CIS_OFS_FLAGS, 32'h0000_0000, 4'he, 6'h00);
		rd(CIS_OFS_FLAGS, 32'h0000_00cf, "flags after unselected write");
		exp = 32'h0000_00cf;
		for (int i = 0; i < 6; i++) begin
			exp = exp & ~(32'h1 << pos[i]);
			wr(CIS_OFS_FLAGS, ~(32'h1 << pos[i]));
			rd(CIS_OFS_FLAGS, exp, "one flag cleared");
		end
		wr(CIS_OFS_FLAGS, 32'h0000_0000, 6'h01);
		rd(CIS_OFS_FLAGS, 32'h0000_0001, "set beats clear");
		wr(CIS_OFS_FLAGS, 32'h0000_0000);
		$display("test events done");
	endtask

	task automatic t_status;
		logic [4:0] s;
		logic [31:0] exp;
		for (int k = 0; k < 5; k++) begin
			s = 5'h01 << k;
			st_req <= s;
			repeat (3) @(posedge clk);
			exp = {18'h0, s, s[1] | s[0], 8'h20};
			rd(CIS_OFS_FLAGS, exp, "status set");
			wr(CIS_OFS_FLAGS, 32'h0000_0000);
			rd(CIS_OFS_FLAGS, exp & ~32'h20, "status kept");
			st_req <= 5'h00;
			repeat (3) @(posedge clk);
			rd(CIS_OFS_FLAGS, 32'h0000_0020, "status left");
			wr(CIS_OFS_FLAGS, 32'h0000_0000);
		end
		$display("test status done");
	endtask

	task automatic t_irq;
		wr(CIS_OFS_ENABLES, 32'h0000_0002);
		bus(1'b0, CIS_OFS_FLAGS, 32'h0000_0000, 4'hf, 6'h02);
		irq_chk(1'b1);
		wr(CIS_OFS_ENABLES, 32'h0000_0001);
		irq_chk(1'b0);
		wr(CIS_OFS_ENABLES, 32'h0000_0002);
		irq_chk(1'b1);
		wr(CIS_OFS_FLAGS, 32'h0000_0000);
		irq_chk(1'b0);
		$display("test irq done");
	endtask

	// Events offered while the clock enable is low must be lost
	task automatic t_freeze;
		@(posedge clk);
		ce <= 1'b0;
		ev_req <= 6'h3f;
		@(posedge clk);
		ev_req <= 6'h00;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		rd(CIS_OFS_FLAGS, 32'h0000_0000, "event while frozen");
		$display("test freeze done");
	endtask

	task automatic t_rerun;
		wr(CIS_OFS_ENABLES, 32'h0000_00ff);
		bus(1'b0, CIS_OFS_FLAGS, 32'h0000_0000, 4'hf, 6'h3f);
		irq_chk(1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		irq_chk(1'b0);
		rd(CIS_OFS_FLAGS, 32'h0000_0000, "flags after second reset");
		rd(CIS_OFS_ENABLES, 32'h0000_0000, "enables after second reset");
		$display("test rerun done");
	endtask

	// ------------------------------------------------------------
	// Sequence and verdict
	// ------------------------------------------------------------
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_enables();
		t_events();
		t_status();
		t_irq();
		t_freeze();
		t_rerun();
		test_done();
	end

	// Whole run is well under a thousand cycles
	initial begin
		#100000;
		num_errors++;
		$display("mismatch watchdog expected done seen timeout");
		test_done();
	end
endmodule

`default_nettype wire
